//--- hdl/diskette_pkg.sv
// Package of constants and types for the diskette drive interface.
package diskette_pkg;
    localparam int FIFO_DEPTH = 16;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0C;
    localparam logic [7:0] OFS_STEP = 8'h10;
    localparam logic [7:0] OFS_DATA = 8'h14;
    localparam logic [7:0] OFS_WRITE = 8'h18;
    localparam int CTL_SELECT = 0;
    localparam int CTL_MOTOR = 1;
    localparam int CTL_DIR = 2;
    localparam int CTL_HEAD1 = 3;
    localparam int CTL_CAP144 = 4;
    localparam int CTL_RATE250 = 5;
    localparam int CTL_BURST = 6;
    localparam int CTL_WENABLE = 7;
    localparam int CTL_DENSOUT = 8;
    localparam int CTL_CHGACK = 9;
    localparam int EV_INDEX = 0;
    localparam int EV_STEPDONE = 1;
    localparam int EV_RXREADY = 2;
    localparam int EV_CHANGE = 3;
    localparam int EV_TXEMPTY = 4;
    localparam logic [9:0] CTRL_RESET = 10'h010;
    localparam logic [15:0] STEP_WIDTH_RESET = 16'h0008;
    localparam logic [15:0] STEP_GAP_RESET = 16'h0190;
    localparam int MCLK_MHZ = 125;
    localparam int RATE500_KBPS = 500;
    localparam int RATE250_KBPS = 250;
    localparam int BIT500_CYC = MCLK_MHZ * 1000 / RATE500_KBPS;
    localparam int BIT250_CYC = MCLK_MHZ * 1000 / RATE250_KBPS;
    localparam int BURST_LEVEL = 8;
    typedef enum {STEP_IDLE, STEP_ACTIVE, STEP_GAP} step_state_t;
endpackage

//--- hdl/diskette_drive_interface.sv
// Host-side diskette drive interface with AXI4-Lite register access.
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`default_nettype none
module diskette_drive_interface #(
    parameter int DEPTH = diskette_pkg::FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset,
    // AXI4-Lite slave.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt.
    output logic irq,
    // Drive outputs.
    output logic unitSelect_n,
    output logic spindleOn_n,
    output logic direction,
    output logic stepPulse_n,
    output logic writeWindow_n,
    output logic writeBit,
    output logic sideChoice,
    output logic capacitySelect,
    output logic densityChoice,
    // Drive inputs.
    input wire logic rotationMark_n,
    input wire logic outer_cylinder_flag_n,
    input wire logic mediaLocked_n,
    input wire logic densitySense_n,
    input wire logic mediaSwapped_n,
    input wire logic readBit
);
    import diskette_pkg::*;

    // Three-stage pin synchronisers; stage 0 feeds only stage 1.
    logic [5:0] pinRaw;
    logic [5:0] sync0_ff, sync1_ff, sync2_ff, pin_ff;
    logic [5:0] nxt_pin;
    assign pinRaw = {readBit, mediaSwapped_n, densitySense_n, mediaLocked_n,
                     outer_cylinder_flag_n, rotationMark_n};
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_pin
            always_comb begin
                nxt_pin[gi] = (sync1_ff[gi] == sync2_ff[gi]) ?
                              sync2_ff[gi] : pin_ff[gi];
            end
        end
    endgenerate
    always_ff @(posedge mclk) begin
        if (reset) begin
            sync0_ff <= 6'h3F;
            sync1_ff <= 6'h3F;
            sync2_ff <= 6'h3F;
            pin_ff <= 6'h3F;
        end else begin
            sync0_ff <= pinRaw;
            sync1_ff <= sync0_ff;
            sync2_ff <= sync1_ff;
            pin_ff <= nxt_pin;
        end
    end

    // Register state.
    logic [9:0] ctrl_ff, nxt_ctrl;
    logic [4:0] irqStat_ff, nxt_irqStat, irqMask_ff, nxt_irqMask, events;
    logic [15:0] stepWidth_ff, nxt_stepWidth, stepGap_ff, nxt_stepGap;
    logic [7:0] rxFifo_ff [DEPTH], nxt_rxFifo [DEPTH];
    logic [7:0] txFifo_ff [DEPTH], nxt_txFifo [DEPTH];
    logic [$clog2(DEPTH):0] rxCnt_ff, nxt_rxCnt, txCnt_ff, nxt_txCnt;
    logic [7:0] rxSh_ff, nxt_rxSh, txSh_ff, nxt_txSh;
    logic [2:0] rxBit_ff, nxt_rxBit, txBit_ff, nxt_txBit;
    logic txBusy_ff, nxt_txBusy;
    logic [8:0] bitCnt_ff, nxt_bitCnt;
    logic awDone_ff, nxt_awDone, wDone_ff, nxt_wDone;
    logic [7:0] awAddr_ff, nxt_awAddr;
    logic [31:0] wData_ff, nxt_wData;
    logic bvalid_ff, nxt_bvalid, bErr_ff, nxt_bErr;
    logic rvalid_ff, nxt_rvalid, rErr_ff, nxt_rErr;
    logic [31:0] rdata_ff, nxt_rdata;
    step_state_t stepSt_ff, nxt_stepSt;
    logic [15:0] stepCnt_ff, nxt_stepCnt;
    logic stepReq, mark_d_ff, swap_d_ff;

    function automatic logic known(input logic [7:0] a);
        return a == OFS_CTRL || a == OFS_STATUS || a == OFS_IRQ ||
               a == OFS_MASK || a == OFS_STEP || a == OFS_DATA ||
               a == OFS_WRITE;
    endfunction

    logic doWrite, doRead, bitTick, rxPop, txPush, writing;
    logic [7:0] wa;
    logic [31:0] wd;
    assign wa = awDone_ff ? awAddr_ff : s_axi_awaddr;
    assign wd = wDone_ff ? wData_ff : s_axi_wdata;
    assign s_axi_awready = !awDone_ff && !bvalid_ff;
    assign s_axi_wready = !wDone_ff && !bvalid_ff;
    assign doWrite = (awDone_ff || (s_axi_awvalid && s_axi_awready)) &&
                     (wDone_ff || (s_axi_wvalid && s_axi_wready));
    assign s_axi_arready = !rvalid_ff;
    assign doRead = s_axi_arvalid && s_axi_arready;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bErr_ff ? 2'h2 : 2'h0;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rErr_ff ? 2'h2 : 2'h0;
    assign rxPop = doRead && s_axi_araddr == OFS_DATA && rxCnt_ff != 0;
    assign txPush = doWrite && wa == OFS_WRITE && txCnt_ff != DEPTH;

    // Only motor, step and write outputs are gated by unit select; side, capacity, density and direction are not.
    assign unitSelect_n = !ctrl_ff[CTL_SELECT];
    assign spindleOn_n = !(ctrl_ff[CTL_SELECT] &&
                           ctrl_ff[CTL_MOTOR]);
    assign sideChoice = !ctrl_ff[CTL_HEAD1];
    assign capacitySelect = ctrl_ff[CTL_CAP144];
    assign densityChoice = ctrl_ff[CTL_DENSOUT];
    // A locked medium never sees the write window open.
    assign writing = ctrl_ff[CTL_SELECT] && ctrl_ff[CTL_WENABLE] &&
                     pin_ff[2] && txBusy_ff;
    assign writeWindow_n = !writing;
    assign writeBit = writing && txSh_ff[7];
    assign stepPulse_n = !(stepSt_ff == STEP_ACTIVE);
    assign direction = ctrl_ff[CTL_DIR];
    assign stepReq = doWrite && wa == OFS_STEP && wd[31] &&
                     ctrl_ff[CTL_SELECT] && stepSt_ff == STEP_IDLE;
    assign bitTick = bitCnt_ff == 9'h000;
    assign irq = |(irqStat_ff & irqMask_ff);

    always_comb begin
        events = 5'h00;
        events[EV_INDEX] = mark_d_ff && !pin_ff[0];
        events[EV_CHANGE] = swap_d_ff && !pin_ff[4];
        events[EV_RXREADY] = ctrl_ff[CTL_BURST] ?
            (rxCnt_ff == BURST_LEVEL[$clog2(DEPTH):0]) :
            (rxCnt_ff == 1);
        // Counted on the last bit tick so back-to-back bytes each report.
        events[EV_TXEMPTY] = bitTick && txBusy_ff && txBit_ff == 3'h7;
        events[EV_STEPDONE] = stepSt_ff == STEP_GAP && stepCnt_ff == 16'h0000;
    end

    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_irqMask = irqMask_ff;
        nxt_stepWidth = stepWidth_ff;
        nxt_stepGap = stepGap_ff;
        nxt_irqStat = irqStat_ff;
        if (doWrite && wa == OFS_CTRL && s_axi_wstrb[0])
            nxt_ctrl = wd[9:0];
        // Direction must not change while a pulse is on the line.
        if (stepSt_ff == STEP_ACTIVE)
            nxt_ctrl[CTL_DIR] = ctrl_ff[CTL_DIR];
        if (doWrite && wa == OFS_MASK)
            nxt_irqMask = wd[4:0];
        if (doWrite && wa == OFS_STEP && !wd[31]) begin
            nxt_stepWidth = wd[15:0] == 0 ? 16'h0001 : wd[15:0];
            nxt_stepGap = wd[30:16] == 0 ? 16'h0001 : {1'b0, wd[30:16]};
        end
        if (doWrite && wa == OFS_IRQ)
            nxt_irqStat = irqStat_ff & ~wd[4:0];
        nxt_irqStat = nxt_irqStat | events;
        nxt_awDone = awDone_ff;
        nxt_wDone = wDone_ff;
        nxt_awAddr = awAddr_ff;
        nxt_wData = wData_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_awDone = 1'b1;
            nxt_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_wDone = 1'b1;
            nxt_wData = s_axi_wdata;
        end
        nxt_bvalid = bvalid_ff && !s_axi_bready;
        nxt_bErr = bErr_ff;
        if (doWrite) begin
            nxt_awDone = 1'b0;
            nxt_wDone = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bErr = !known(wa);
        end
        nxt_rvalid = rvalid_ff && !s_axi_rready;
        nxt_rdata = rdata_ff;
        nxt_rErr = rErr_ff;
        if (doRead) begin
            nxt_rvalid = 1'b1;
            nxt_rErr = !known(s_axi_araddr);
            case (s_axi_araddr)
                OFS_CTRL: nxt_rdata = {22'h000000, ctrl_ff};
                OFS_STATUS: nxt_rdata = {16'h0000,
                    3'(rxCnt_ff >> 2), 5'(txCnt_ff), stepSt_ff != STEP_IDLE,
                    pin_ff[5], pin_ff[4], pin_ff[3], pin_ff[2], pin_ff[1],
                    pin_ff[0], 1'b0};
                OFS_IRQ: nxt_rdata = {27'h0000000, irqStat_ff};
                OFS_MASK: nxt_rdata = {27'h0000000, irqMask_ff};
                OFS_STEP: nxt_rdata = {stepGap_ff, stepWidth_ff};
                OFS_DATA: nxt_rdata = {23'h000000, rxCnt_ff != 0,
                                       rxFifo_ff[0]};
                default: nxt_rdata = 32'h00000000;
            endcase
        end
    end

    // Step pulse sequencer.
    always_comb begin
        nxt_stepSt = stepSt_ff;
        nxt_stepCnt = stepCnt_ff - 16'h0001;
        case (stepSt_ff)
            STEP_IDLE: begin
                nxt_stepCnt = stepWidth_ff;
                if (stepReq)
                    nxt_stepSt = STEP_ACTIVE;
            end
            STEP_ACTIVE: if (stepCnt_ff == 16'h0001) begin
                nxt_stepSt = STEP_GAP;
                nxt_stepCnt = stepGap_ff;
            end
            STEP_GAP: if (stepCnt_ff == 16'h0000)
                nxt_stepSt = STEP_IDLE;
            default: nxt_stepSt = STEP_IDLE;
        endcase
    end

    // Serial bit engine and FIFOs shifting from index 0.
    always_comb begin
        nxt_bitCnt = bitTick ? (ctrl_ff[CTL_RATE250] ?
            9'(BIT250_CYC - 1) : 9'(BIT500_CYC - 1)) :
            bitCnt_ff - 9'h001;
        nxt_rxFifo = rxFifo_ff;
        nxt_rxCnt = rxCnt_ff;
        nxt_rxSh = rxSh_ff;
        nxt_rxBit = rxBit_ff;
        nxt_txFifo = txFifo_ff;
        nxt_txCnt = txCnt_ff;
        nxt_txSh = txSh_ff;
        nxt_txBit = txBit_ff;
        nxt_txBusy = txBusy_ff;
        if (rxPop) begin
            for (int i = 0; i < DEPTH - 1; i++)
                nxt_rxFifo[i] = rxFifo_ff[i + 1];
            nxt_rxCnt = rxCnt_ff - 1'b1;
        end
        if (bitTick && ctrl_ff[CTL_SELECT] && !writing) begin
            nxt_rxSh = {rxSh_ff[6:0], pin_ff[5]};
            nxt_rxBit = rxBit_ff + 3'h1;
            // A full FIFO drops the byte; software must keep up.
            if (rxBit_ff == 3'h7 && nxt_rxCnt != DEPTH) begin
                nxt_rxFifo[nxt_rxCnt[$clog2(DEPTH)-1:0]] =
                    {rxSh_ff[6:0], pin_ff[5]};
                nxt_rxCnt = nxt_rxCnt + 1'b1;
            end
        end
        if (bitTick && txBusy_ff) begin
            nxt_txSh = {txSh_ff[6:0], 1'b0};
            nxt_txBit = txBit_ff + 3'h1;
            if (txBit_ff == 3'h7)
                nxt_txBusy = 1'b0;
        end
        // Loading only on a tick gives the first bit a full period, and a
        // locked or deselected drive keeps the byte queued instead of lost.
        if (bitTick && !nxt_txBusy && txCnt_ff != 0 &&
            ctrl_ff[CTL_WENABLE] && ctrl_ff[CTL_SELECT] &&
            pin_ff[2]) begin
            nxt_txSh = txFifo_ff[0];
            nxt_txBusy = 1'b1;
            nxt_txBit = 3'h0;
            for (int i = 0; i < DEPTH - 1; i++)
                nxt_txFifo[i] = txFifo_ff[i + 1];
            nxt_txCnt = txCnt_ff - 1'b1;
        end
        if (txPush) begin
            nxt_txFifo[nxt_txCnt[$clog2(DEPTH)-1:0]] = wd[7:0];
            nxt_txCnt = nxt_txCnt + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_ff <= CTRL_RESET;
            irqStat_ff <= 5'h00;
            irqMask_ff <= 5'h00;
            stepWidth_ff <= STEP_WIDTH_RESET;
            stepGap_ff <= STEP_GAP_RESET;
            awDone_ff <= 1'b0;
            wDone_ff <= 1'b0;
            awAddr_ff <= 8'h00;
            wData_ff <= 32'h00000000;
            bvalid_ff <= 1'b0;
            bErr_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rErr_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            stepSt_ff <= STEP_IDLE;
            stepCnt_ff <= 16'h0000;
            bitCnt_ff <= 9'h000;
            rxCnt_ff <= '0;
            txCnt_ff <= '0;
            rxSh_ff <= 8'h00;
            txSh_ff <= 8'h00;
            rxBit_ff <= 3'h0;
            txBit_ff <= 3'h0;
            txBusy_ff <= 1'b0;
            mark_d_ff <= 1'b1;
            swap_d_ff <= 1'b1;
            for (int i = 0; i < DEPTH; i++) begin
                rxFifo_ff[i] <= 8'h00;
                txFifo_ff[i] <= 8'h00;
            end
        end else begin
            ctrl_ff <= nxt_ctrl;
            irqStat_ff <= nxt_irqStat;
            irqMask_ff <= nxt_irqMask;
            stepWidth_ff <= nxt_stepWidth;
            stepGap_ff <= nxt_stepGap;
            awDone_ff <= nxt_awDone;
            wDone_ff <= nxt_wDone;
            awAddr_ff <= nxt_awAddr;
            wData_ff <= nxt_wData;
            bvalid_ff <= nxt_bvalid;
            bErr_ff <= nxt_bErr;
            rvalid_ff <= nxt_rvalid;
            rErr_ff <= nxt_rErr;
            rdata_ff <= nxt_rdata;
            stepSt_ff <= nxt_stepSt;
            stepCnt_ff <= nxt_stepCnt;
            bitCnt_ff <= nxt_bitCnt;
            rxCnt_ff <= nxt_rxCnt;
            txCnt_ff <= nxt_txCnt;
            rxSh_ff <= nxt_rxSh;
            txSh_ff <= nxt_txSh;
            rxBit_ff <= nxt_rxBit;
            txBit_ff <= nxt_txBit;
            txBusy_ff <= nxt_txBusy;
            mark_d_ff <= pin_ff[0];
            swap_d_ff <= pin_ff[4];
            rxFifo_ff <= nxt_rxFifo;
            txFifo_ff <= nxt_txFifo;
        end
    end

    step_dir_a: assert property (@(posedge mclk) disable iff (reset)
        !stepPulse_n |=> $stable(direction)) else $error("dir moved");
    step_width_a: assert property (@(posedge mclk) disable iff (reset)
        $fell(stepPulse_n) && stepWidth_ff == 16'h0005 |=>
        !stepPulse_n [*4] ##1 stepPulse_n)
        else $error("step width wrong");
    step_sel_a: assert property (@(posedge mclk) disable iff (reset)
        $fell(stepPulse_n) |-> !unitSelect_n)
        else $error("step unsel");
    motor_sel_a: assert property (@(posedge mclk) disable iff (reset)
        !spindleOn_n |-> !unitSelect_n) else $error("motor unsel");
    write_lock_a: assert property (@(posedge mclk) disable iff (reset)
        !pin_ff[2] |-> writeWindow_n) else $error("write on lock");
    write_data_a: assert property (@(posedge mclk) disable iff (reset)
        writeWindow_n |-> !writeBit) else $error("data outside");
    cap_sel_a: assert property (@(posedge mclk) disable iff (reset)
        capacitySelect == ctrl_ff[CTL_CAP144]) else $error("cap");
    head_sel_a: assert property (@(posedge mclk) disable iff (reset)
        sideChoice == !ctrl_ff[CTL_HEAD1]) else $error("head");
    fifo_bound_a: assert property (@(posedge mclk) disable iff (reset)
        rxCnt_ff <= DEPTH && txCnt_ff <= DEPTH) else $error("fifo");
    rate_tick_a: assert property (@(posedge mclk) disable iff (reset)
        bitCnt_ff <= 9'(BIT250_CYC - 1)) else $error("rate count");
    swap_irq_a: assert property (@(posedge mclk) disable iff (reset)
        $fell(pin_ff[4]) |=> irqStat_ff[EV_CHANGE])
        else $error("swap");
endmodule // diskette_drive_interface
`default_nettype wire

//--- testbench/drive_model.sv
// Behavioural model of the diskette drive mechanism.
`default_nettype none
module drive_model (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset,
    // Host lines.
    input wire logic unitSelect_n,
    input wire logic spindleOn_n,
    input wire logic direction,
    input wire logic stepPulse_n,
    // Drive lines.
    output logic rotationMark_n,
    output logic outer_cylinder_flag_n,
    output logic mediaLocked_n,
    output logic densitySense_n,
    output logic mediaSwapped_n,
    output logic readBit,
    // Scenario controls.
    input wire logic protect,
    input wire logic highDensity,
    input wire logic swapDisk,
    output int cylinder
);
    timeunit 1ns;
    timeprecision 1ps;
    logic stepQ;
    logic spin;
    int turn;
    logic [7:0] pat;
    assign outer_cylinder_flag_n = (cylinder != 0);
    assign mediaLocked_n = !protect;
    assign densitySense_n = !highDensity;
    assign spin = !unitSelect_n && !spindleOn_n;
    always_ff @(posedge mclk) begin
        stepQ <= stepPulse_n;
        turn <= (spin && turn < 1999) ? turn + 1 : 0;
        rotationMark_n <= !(spin && turn < 8);
        if (reset) begin
            cylinder <= 2;
            pat <= 8'hC5;
            mediaSwapped_n <= 1'b1;
            readBit <= 1'b0;
        end else begin
            if (!unitSelect_n && stepPulse_n && !stepQ) begin
                cylinder <= direction ? (cylinder == 0 ? 0 : cylinder - 1)
                    : cylinder + 1;
                mediaSwapped_n <= 1'b1;
            end
            if (swapDisk) begin
                mediaSwapped_n <= 1'b0;
            end
            // A released line shows no stale level, so it toggles.
            if (unitSelect_n) begin
                readBit <= !readBit;
            end else if (turn % 250 == 0) begin
                readBit <= pat[7];
                pat <= {pat[6:0], pat[7] ^ pat[5]};
            end
        end
    end
endmodule // drive_model
`default_nettype wire

//--- testbench/tb.sv
// Self-checking testbench of the diskette drive interface.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import diskette_pkg::*;
    logic mclk = 1'b0, reset = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    logic protect = 1'b0, highDensity = 1'b1, swapDisk = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq, unitSelect_n, spindleOn_n, direction;
    logic stepPulse_n, writeWindow_n, writeBit, sideChoice, readBit;
    logic capacitySelect, densityChoice, rotationMark_n, mediaSwapped_n;
    logic outer_cylinder_flag_n, mediaLocked_n, densitySense_n;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd;
    logic [5:0] pins;
    int cylinder, errTotal = 0, nCompared = 0;
    assign pins = {unitSelect_n, spindleOn_n, direction, sideChoice,
        capacitySelect, densityChoice};
    diskette_drive_interface i_dut (.mclk, .reset, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq,
        .unitSelect_n, .spindleOn_n, .direction, .stepPulse_n,
        .writeWindow_n, .writeBit, .sideChoice, .capacitySelect,
        .densityChoice, .rotationMark_n, .outer_cylinder_flag_n,
        .mediaLocked_n, .densitySense_n, .mediaSwapped_n, .readBit);
    drive_model i_drive (.mclk, .reset, .unitSelect_n, .spindleOn_n,
        .direction, .stepPulse_n, .rotationMark_n, .outer_cylinder_flag_n,
        .mediaLocked_n, .densitySense_n, .mediaSwapped_n, .readBit,
        .protect, .highDensity, .swapDisk, .cylinder);
    always #4 mclk = ~mclk;
    function automatic logic [5:0] pinsExp(input logic [9:0] c);
        return {~c[CTL_SELECT], ~(c[CTL_SELECT] & c[CTL_MOTOR]), c[CTL_DIR],
            ~c[CTL_HEAD1], c[CTL_CAP144], c[CTL_DENSOUT]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errTotal++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stopTest();
        $display("Compared %0d, mismatches %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Readiness is looked at mid-cycle; it cannot move before the edge.
    // Response ready lines stay high, so back-to-back calls never toggle them.
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        repeat (100) begin
            @(negedge mclk);
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                @(posedge mclk);
                return;
            end
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
            @(posedge mclk);
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
        end
        errTotal++;
    endtask
    task automatic axiRead(input logic [7:0] a);
        logic t;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        repeat (100) begin
            @(negedge mclk);
            if (s_axi_rvalid) begin
                rd = s_axi_rdata;
                resp = s_axi_rresp;
                @(posedge mclk);
                return;
            end
            t = s_axi_arready;
            @(posedge mclk);
            if (t) begin
                s_axi_arvalid <= 1'b0;
            end
        end
        errTotal++;
    endtask
    initial begin
        repeat (30000) @(posedge mclk);
        errTotal++;
        stopTest();
    end
    initial begin
        logic [31:0] d;
        logic [7:0] b, got;
        int w;
        void'($urandom(93732));
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        check(32'(pins), 32'(pinsExp(CTRL_RESET)));
        axiRead(OFS_CTRL);
        check(rd, {22'h0, CTRL_RESET});
        for (int i = 0; i < 12; i++) begin
            d = (i < 2) ? (i ? 32'h37F : 32'h0) : ($urandom & 32'h37F);
            axiWrite(OFS_CTRL, d);
            check(resp, 32'h0);
            repeat (2) @(posedge mclk);
            check(32'(pins), 32'(pinsExp(d[9:0])));
            axiRead(OFS_CTRL);
            check(rd, d);
        end
        axiWrite(8'h40, 32'h1);
        check(resp, 32'h2);
        axiRead(8'h40);
        check({resp, rd[29:0]}, 32'h8000_0000);
        axiWrite(OFS_CTRL, 32'h017);
        axiWrite(OFS_MASK, 32'h02);
        axiWrite(OFS_STEP, {1'b0, 15'h000A, 16'h0005});
        for (int s = 0; s < 4; s++) begin
            if (s == 2) axiWrite(OFS_CTRL, 32'h013);
            if (s == 3) axiWrite(OFS_MASK, 32'h00);
            axiWrite(OFS_STEP, 32'h8000_0000);
            for (int t = 0; t < 50 && stepPulse_n; t++) @(negedge mclk);
            w = 0;
            while (!stepPulse_n && w < 100) begin
                @(negedge mclk);
                w++;
            end
            check(w, 5);
            repeat (30) @(posedge mclk);
            check(cylinder, s == 0 ? 1 : s - 1);
            check(irq, s < 3);
            axiRead(OFS_STATUS);
            check(rd[2], s != 1);
            axiWrite(OFS_IRQ, 32'h02);
            check(irq, 0);
        end
        repeat (2100) @(posedge mclk);
        axiRead(OFS_IRQ);
        check(rd[0], 1);
        axiRead(OFS_DATA);
        check(rd[8], 1);
        swapDisk <= 1'b1;
        @(posedge mclk);
        swapDisk <= 1'b0;
        repeat (10) @(posedge mclk);
        axiRead(OFS_STATUS);
        check(rd[5:4], 0);
        axiRead(OFS_IRQ);
        check(rd[3], 1);
        axiWrite(OFS_STEP, 32'h8000_0000);
        repeat (40) @(posedge mclk);
        axiRead(OFS_STATUS);
        check(rd[5], 1);
        protect <= 1'b1;
        repeat (8) @(posedge mclk);
        b = 8'($urandom);
        axiWrite(OFS_CTRL, 32'h093);
        axiWrite(OFS_WRITE, {24'h0, b});
        w = 0;
        repeat (600) begin
            @(negedge mclk);
            w += !writeWindow_n;
        end
        check(w, 0);
        @(posedge mclk);
        protect <= 1'b0;
        for (int t = 0; t < 300 && writeWindow_n; t++) @(negedge mclk);
        repeat (125) @(negedge mclk);
        for (int k = 0; k < 8; k++) begin
            got = {got[6:0], writeBit};
            check(writeWindow_n, 0);
            repeat (BIT500_CYC) @(negedge mclk);
        end
        check(got, b);
        @(posedge mclk);
        axiWrite(OFS_CTRL, 32'h013);
        repeat (FIFO_DEPTH + 1) axiWrite(OFS_WRITE, 32'($urandom & 8'hFF));
        axiRead(OFS_STATUS);
        check(rd[12:8], FIFO_DEPTH);
        stopTest();
    end
endmodule // tb
`default_nettype wire
